//--- fcs_pkg.sv
/*
 * Constants for the host-side controller of a parallel NOR flash command
 * state machine: register map, operation codes, bus-cycle timing, command
 * codes. Assumes a 125 MHz system clock and an asynchronous flash bus.
 */
// Contract
// - Write only with CE, WE low, OE high
// - Host writes reset after timeout flag or autoselect; the controller reads no timeout flag
// - Autoselect: two unlocks then autoselect command
// - Host leaves autoselect only with reset command
// - Program is two unlocks, setup, address/data
// - Bypass entry: two unlocks then bypass code
// - Bypass program: command then address/data
// - Bypass accepts only program and two-cycle exit
package fcs_pkg;

   // ****************************************************************
   // Register map (byte addresses, one word each)
   // ****************************************************************
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_RDATA  = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_CFG    = 8'h14;

   localparam int CTRL_GO_BIT     = 31;
   localparam int STAT_BUSY_BIT   = 0;
   localparam int STAT_BYPASS_BIT = 1;
   localparam int STAT_AUTO_BIT   = 2;
   localparam int STAT_ERR_BIT    = 3;
   localparam int STAT_RB_BIT     = 4;
   localparam int CFG_BYTE_BIT    = 0;
   localparam int CFG_HWRST_BIT   = 1;
   localparam int CFG_HV_BIT      = 2;
   localparam logic [2:0] CFG_RESET = 3'h0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;

   typedef enum logic [3:0] {
      OP_READ, OP_RESET, OP_PROG, OP_AUTOSEL,
      OP_BYP_ENTER, OP_BYP_PROG, OP_BYP_EXIT, OP_RAW_WRITE
   } fcs_op_e;

   // ****************************************************************
   // Command codes and unlock cycles
   // ****************************************************************
   localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 18'h00555;
   localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 18'h002aa;
   localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00aa;
   localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
   localparam logic [DATA_W-1:0] CMD_RESET    = 16'h00f0;
   localparam logic [DATA_W-1:0] CMD_AUTOSEL  = 16'h0090;
   localparam logic [DATA_W-1:0] CMD_PROG     = 16'h00a0;
   localparam logic [DATA_W-1:0] CMD_BYPASS   = 16'h0020;
   localparam logic [DATA_W-1:0] CMD_BYP_PROG = 16'h00a0;
   localparam logic [DATA_W-1:0] CMD_BYP_EX1  = 16'h0090;
   localparam logic [DATA_W-1:0] CMD_BYP_EX2  = 16'h0000;

   // ****************************************************************
   // Bus timing
   // ****************************************************************
   localparam int CLK_PS      = 8000;
   localparam int T_SETUP_NS  = 30;
   localparam int T_WP_NS     = 70;
   localparam int T_WPH_NS    = 40;
   localparam int T_ACC_NS    = 100;
   localparam int T_BUSY_NS   = 90;
   localparam int C_SETUP = (T_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int C_WP    = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int C_WPH   = (T_WPH_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int C_ACC   = (T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS + 2;
   localparam int C_BUSY  = (T_BUSY_NS * 1000 + CLK_PS - 1) / CLK_PS;

endpackage

//--- fcs_host_ctrl.sv
/*
 * Host controller for a parallel NOR flash. Software orders single reads,
 * command sequences and programs through AXI4-Lite registers; the module
 * runs the asynchronous bus cycles on the flash pins.
 * Assumes flash pins are asynchronous to ref_clk_i and the board resolves
 * the data bus from flash_dq_oe_o.
 */
`timescale 1ns/1ps
module fcs_host_ctrl
   import fcs_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              srst_i,
   input  wire logic [7:0]        s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output logic                   s_axi_awready_o,
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output logic                   s_axi_wready_o,
   output logic [1:0]             s_axi_bresp_o,
   output logic                   s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   input  wire logic [7:0]        s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output logic                   s_axi_arready_o,
   output logic [31:0]            s_axi_rdata_o,
   output logic [1:0]             s_axi_rresp_o,
   output logic                   s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i,
   output logic                   flash_ce_n_o,
   output logic                   flash_we_n_o,
   output logic                   flash_oe_n_o,
   output logic [ADDR_W-1:0]      flash_addr_o,
   input  wire logic [DATA_W-1:0] flash_dq_i,
   output logic [DATA_W-1:0]      flash_dq_o,
   output logic                   flash_dq_oe_o,
   output logic                   flash_byte_n_o,
   output logic                   flash_reset_n_o,
   output logic                   id_high_voltage_en_o,
   input  wire logic              ready_busy_pin_n_i
);

   typedef enum logic [2:0] {
      ST_IDLE, ST_W_SETUP, ST_W_PULSE, ST_W_HOLD, ST_R_ACC, ST_BUSY_WAIT
   } fcs_state_e;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [DATA_W-1:0] dq_meta_q, dq_sync_q;
   logic              rb_meta_q, rb_sync_q;

   always_ff @(posedge ref_clk_i)
   begin
      dq_meta_q <= flash_dq_i;
      dq_sync_q <= dq_meta_q;
      rb_meta_q <= ready_busy_pin_n_i;
      rb_sync_q <= rb_meta_q;
   end

   // ****************************************************************
   // Registers and bus slave
   // ****************************************************************
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q, rdata_q;
   logic [2:0]        cfg_q;
   fcs_op_e           op_q;
   logic              busy_q, bypass_q, auto_q, err_q;
   logic              bvalid_q, rvalid_q;
   logic [1:0]        bresp_q, rresp_q;
   logic [31:0]       rd_q;
   logic              wr_take, rd_take, go;

   assign wr_take         = s_axi_awvalid_i && s_axi_wvalid_i && !bvalid_q;
   assign s_axi_awready_o = wr_take;
   assign s_axi_wready_o  = wr_take;
   assign rd_take         = s_axi_arvalid_i && !rvalid_q;
   assign s_axi_arready_o = rd_take;
   assign s_axi_bvalid_o  = bvalid_q;
   assign s_axi_bresp_o   = bresp_q;
   assign s_axi_rvalid_o  = rvalid_q;
   assign s_axi_rresp_o   = rresp_q;
   assign s_axi_rdata_o   = rd_q;
   // Orders arriving while a sequence runs are dropped so the pins never glitch
   assign go = wr_take && s_axi_awaddr_i == REG_CTRL && s_axi_wstrb_i[3]
               && s_axi_wdata_i[CTRL_GO_BIT] && !busy_q;

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end
      else if (wr_take)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= (s_axi_awaddr_i == REG_CTRL || s_axi_awaddr_i == REG_ADDR ||
                      s_axi_awaddr_i == REG_WDATA || s_axi_awaddr_i == REG_CFG) ?
                     RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_i)
         bvalid_q <= 1'b0;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         addr_q  <= '0;
         wdata_q <= '0;
         cfg_q   <= CFG_RESET;
      end
      else if (wr_take)
      begin
         if (s_axi_awaddr_i == REG_ADDR)
            addr_q <= s_axi_wdata_i[ADDR_W-1:0];
         if (s_axi_awaddr_i == REG_WDATA)
            wdata_q <= s_axi_wdata_i[DATA_W-1:0];
         if (s_axi_awaddr_i == REG_CFG)
            cfg_q <= s_axi_wdata_i[2:0];
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         rvalid_q <= 1'b0;
         rresp_q  <= RESP_OKAY;
         rd_q     <= '0;
      end
      else if (rd_take)
      begin
         rvalid_q <= 1'b1;
         rresp_q  <= RESP_OKAY;
         case (s_axi_araddr_i)
            REG_CTRL:   rd_q <= {28'h0000000, op_q};
            REG_ADDR:   rd_q <= {14'h0000, addr_q};
            REG_WDATA:  rd_q <= {16'h0000, wdata_q};
            REG_RDATA:  rd_q <= {16'h0000, rdata_q};
            REG_STATUS: rd_q <= {27'h0000000, rb_sync_q, err_q, auto_q, bypass_q, busy_q};
            REG_CFG:    rd_q <= {29'h00000000, cfg_q};
            default:
            begin
               rd_q    <= '0;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready_i)
         rvalid_q <= 1'b0;
   end

   // ****************************************************************
   // Step table
   // ****************************************************************
   function automatic logic [ADDR_W+DATA_W-1:0] step_word(input fcs_op_e op,
      input logic [1:0] idx, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] cmd;
      cmd = CMD_PROG;
      if (op == OP_AUTOSEL)
         cmd = CMD_AUTOSEL;
      else if (op == OP_BYP_ENTER)
         cmd = CMD_BYPASS;
      case (op)
         OP_PROG, OP_AUTOSEL, OP_BYP_ENTER:
            case (idx)
               2'h0:    step_word = {UNLOCK1_ADDR, UNLOCK1_DATA};
               2'h1:    step_word = {UNLOCK2_ADDR, UNLOCK2_DATA};
               2'h2:    step_word = {UNLOCK1_ADDR, cmd};
               default: step_word = {a, d};
            endcase
         OP_BYP_PROG:
            step_word = (idx == 2'h0) ? {UNLOCK1_ADDR, CMD_BYP_PROG} : {a, d};
         OP_BYP_EXIT:
            step_word = (idx == 2'h0) ? {a, CMD_BYP_EX1} : {a, CMD_BYP_EX2};
         OP_RESET:
            step_word = {a, CMD_RESET};
         default:
            step_word = {a, d};
      endcase
   endfunction

   function automatic logic [1:0] last_step(input fcs_op_e op);
      case (op)
         OP_PROG:                 last_step = 2'h3;
         OP_AUTOSEL, OP_BYP_ENTER: last_step = 2'h2;
         OP_BYP_PROG, OP_BYP_EXIT: last_step = 2'h1;
         default:                 last_step = 2'h0;
      endcase
   endfunction

   // ****************************************************************
   // Bus cycle sequencer
   // ****************************************************************
   fcs_state_e                st_q;
   logic [1:0]                idx_q;
   logic [7:0]                cnt_q;
   logic [ADDR_W+DATA_W-1:0]  step;
   fcs_op_e                   new_op;
   logic                      refuse;

   assign step   = step_word(op_q, idx_q, addr_q, wdata_q);
   assign new_op = fcs_op_e'(s_axi_wdata_i[3:0]);
   // Bypass mode takes only reads, its own program and exit; autoselect only reads, reset or raw writes
   always_comb
   begin
      refuse = 1'b0;
      if (bypass_q)
         refuse = !(new_op inside {OP_READ, OP_BYP_PROG, OP_BYP_EXIT});
      else if (new_op inside {OP_BYP_PROG, OP_BYP_EXIT})
         refuse = 1'b1;
      else if (auto_q)
         refuse = !(new_op inside {OP_READ, OP_RESET, OP_RAW_WRITE});
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         st_q     <= ST_IDLE;
         op_q     <= OP_READ;
         idx_q    <= 2'h0;
         cnt_q    <= 8'h00;
         busy_q   <= 1'b0;
         err_q    <= 1'b0;
         bypass_q <= 1'b0;
         auto_q   <= 1'b0;
         rdata_q  <= '0;
      end
      else
      begin
         case (st_q)
            ST_IDLE:
               if (go)
               begin
                  err_q <= refuse;
                  idx_q <= 2'h0;
                  cnt_q <= 8'h00;
                  if (!refuse)
                  begin
                     op_q   <= new_op;
                     busy_q <= 1'b1;
                     st_q   <= (new_op == OP_READ) ? ST_R_ACC : ST_W_SETUP;
                  end
               end
            ST_W_SETUP:
               if (cnt_q == 8'(C_SETUP))
               begin
                  cnt_q <= 8'h00;
                  st_q  <= ST_W_PULSE;
               end
               else
                  cnt_q <= cnt_q + 8'h01;
            ST_W_PULSE:
               if (cnt_q == 8'(C_WP))
               begin
                  cnt_q <= 8'h00;
                  st_q  <= ST_W_HOLD;
               end
               else
                  cnt_q <= cnt_q + 8'h01;
            ST_W_HOLD:
               if (cnt_q == 8'(C_WPH))
               begin
                  cnt_q <= 8'h00;
                  if (idx_q != last_step(op_q))
                  begin
                     idx_q <= idx_q + 2'h1;
                     st_q  <= ST_W_SETUP;
                  end
                  else if (op_q == OP_PROG || op_q == OP_BYP_PROG)
                     st_q <= ST_BUSY_WAIT;
                  else
                  begin
                     busy_q <= 1'b0;
                     st_q   <= ST_IDLE;
                     case (op_q)
                        OP_RESET:
                        begin
                           auto_q <= 1'b0;
                           bypass_q <= 1'b0;
                        end
                        OP_AUTOSEL:   auto_q <= 1'b1;
                        OP_BYP_ENTER: bypass_q <= 1'b1;
                        OP_BYP_EXIT:  bypass_q <= 1'b0;
                        default:      auto_q <= auto_q;
                     endcase
                  end
               end
               else
                  cnt_q <= cnt_q + 8'h01;
            ST_R_ACC:
               if (cnt_q == 8'(C_ACC))
               begin
                  rdata_q <= dq_sync_q;
                  busy_q  <= 1'b0;
                  st_q    <= ST_IDLE;
               end
               else
                  cnt_q <= cnt_q + 8'h01;
            ST_BUSY_WAIT:
               // Busy pin may lag the last write edge, so give it time to fall
               if (cnt_q != 8'(C_BUSY))
                  cnt_q <= cnt_q + 8'h01;
               else if (rb_sync_q)
               begin
                  busy_q <= 1'b0;
                  st_q   <= ST_IDLE;
               end
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Pin drivers
   // ****************************************************************
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         flash_ce_n_o  <= 1'b1;
         flash_we_n_o  <= 1'b1;
         flash_oe_n_o  <= 1'b1;
         flash_addr_o  <= '0;
         flash_dq_o    <= '0;
         flash_dq_oe_o <= 1'b0;
      end
      else
      begin
         // WE falls after CE and rises with it, so WE sets both latch edges
         flash_ce_n_o  <= !(st_q inside {ST_W_SETUP, ST_W_PULSE, ST_R_ACC});
         flash_we_n_o  <= st_q != ST_W_PULSE;
         flash_oe_n_o  <= st_q != ST_R_ACC;
         flash_dq_oe_o <= st_q inside {ST_W_SETUP, ST_W_PULSE, ST_W_HOLD};
         if (st_q == ST_R_ACC)
            flash_addr_o <= addr_q;
         else if (st_q inside {ST_W_SETUP, ST_W_PULSE, ST_W_HOLD})
         begin
            flash_addr_o <= step[ADDR_W+DATA_W-1:DATA_W];
            flash_dq_o   <= step[DATA_W-1:0];
         end
      end
   end

   assign flash_byte_n_o       = !cfg_q[CFG_BYTE_BIT];
   assign flash_reset_n_o      = !cfg_q[CFG_HWRST_BIT];
   assign id_high_voltage_en_o = cfg_q[CFG_HV_BIT];

endmodule

//--- fcs_host_ctrl_assertions.sv
/* Concurrent checks on the host controller's AXI and flash pins.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
module fcs_host_ctrl_assertions
   import fcs_pkg::*;
(
   input wire logic       ref_clk_i,
   input wire logic       srst_i,
   input wire logic       s_axi_awvalid_i,
   input wire logic       s_axi_wvalid_i,
   input wire logic       s_axi_bvalid_o,
   input wire logic       s_axi_bready_i,
   input wire logic       s_axi_arvalid_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic       s_axi_rvalid_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic       flash_ce_n_o,
   input wire logic       flash_we_n_o,
   input wire logic       flash_oe_n_o,
   input wire logic       flash_dq_oe_o
);
   // ****************************************************************
   // Pin and bus relations
   // ****************************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   a_we_qualified: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o)
      else $error("write strobe without chip enable or with output enable");
   a_oe_no_drive: assert property (!flash_oe_n_o |-> flash_we_n_o && !flash_dq_oe_o)
      else $error("read overlaps a write or a driven bus");
   a_addr_setup: assert property ($fell(flash_we_n_o) |->
      $past(!flash_ce_n_o && flash_we_n_o && flash_dq_oe_o, 5))
      else $error("write setup too short");
   a_pulse_width: assert property ($fell(flash_we_n_o) |->
      (!flash_we_n_o)[*8] ##1 (!flash_we_n_o)[*2] ##1 flash_we_n_o)
      else $error("write pulse not ten cycles");
   a_data_hold: assert property ($rose(flash_we_n_o) |->
      (flash_ce_n_o && flash_dq_oe_o)[*6])
      else $error("data released too early after write");
   a_read_len: assert property ($fell(flash_oe_n_o) |->
      (!flash_oe_n_o && !flash_ce_n_o)[*8] ##1 (!flash_oe_n_o)[*8] ##1 flash_oe_n_o)
      else $error("read cycle not sixteen cycles");
   a_b_next: assert property (s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o
      |=> s_axi_bvalid_o)
      else $error("write response late");
   a_b_once: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
      else $error("write response repeated");
   a_r_next: assert property (s_axi_arvalid_i && !s_axi_rvalid_o |=> s_axi_rvalid_o)
      else $error("read response late");
   a_unmapped_err: assert property (s_axi_arvalid_i && !s_axi_rvalid_o
      && s_axi_araddr_i > 8'h14 |=> s_axi_rresp_o == RESP_SLVERR)
      else $error("unmapped read not refused");
endmodule

bind fcs_host_ctrl fcs_host_ctrl_assertions u_fcs_host_ctrl_assertions (
   .ref_clk_i(ref_clk_i), .srst_i(srst_i), .s_axi_awvalid_i(s_axi_awvalid_i),
   .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_araddr_i(s_axi_araddr_i), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rresp_o(s_axi_rresp_o), .flash_ce_n_o(flash_ce_n_o), .flash_we_n_o(flash_we_n_o),
   .flash_oe_n_o(flash_oe_n_o), .flash_dq_oe_o(flash_dq_oe_o));

//--- fcs_flash_model.sv
/* Behavioural flash device: command sequencer, small array, id codes.
   Assumes the bench resolves the shared data bus from the host's data enable. */
`timescale 1ns/1ps
module fcs_flash_model
   import fcs_pkg::*;
#(
   parameter logic [15:0] MFR_CODE = 16'h00c3, // Arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h5a3c  // Arbitrary value
)(
   input  wire logic              ce_n_i,
   input  wire logic              we_n_i,
   input  wire logic              oe_n_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] dq_i,
   input  wire logic              byte_n_i,
   input  wire logic              reset_n_i,
   input  wire logic              hv_i,
   output logic      [DATA_W-1:0] dq_o,
   output logic                   rb_n_o
);
   // ****************************************************************
   // Array, state, read path
   // ****************************************************************
   logic [DATA_W-1:0] mem [32];
   logic [DATA_W-1:0] val;
   logic [DATA_W-1:0] last_q = 16'h0;
   logic [ADDR_W-1:0] a_q;
   logic [2:0]        st = 3'h0;
   logic              busy = 1'b0;
   wire               wend = ce_n_i | we_n_i;
   initial
   begin
      foreach (mem[i]) mem[i] = 16'hffff;
   end
   always_comb
      if (st == 3'h4)
         val = addr_i[7:0] == 8'h00 ? MFR_CODE : addr_i[7:0] == 8'h01 ? DEV_CODE
             : {15'h0, addr_i[17] & !hv_i};
      else
         val = mem[{addr_i[17], addr_i[3:0]}];
   // A released bus shows the inverse of the last read, never a stale copy
   assign dq_o   = (!ce_n_i && !oe_n_i) ? val : ~last_q;
   assign rb_n_o = !busy;
   always @(posedge oe_n_i) last_q <= val;
   always @(negedge wend) a_q <= addr_i;
   always @(posedge busy)
   begin
      #200;
      busy = 1'b0;
   end
   task automatic prog(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      if (!a[17] || hv_i)
         mem[{a[17], a[3:0]}] &= byte_n_i ? d : {8'hff, d[7:0]};
      busy = 1'b1;
   endtask
   always @(posedge wend or negedge reset_n_i)
      if (!reset_n_i)
      begin
         st <= 3'h0;
         busy = 1'b0;
      end
      else if (oe_n_i && !busy)
         if (dq_i == CMD_RESET && (st < 3'h3 || st == 3'h4))
            st <= 3'h0;
         else
            case (st)
               3'h0: st <= (a_q == UNLOCK1_ADDR && dq_i == UNLOCK1_DATA) ? 3'h1 : 3'h0;
               3'h1: st <= (a_q == UNLOCK2_ADDR && dq_i == UNLOCK2_DATA) ? 3'h2 : 3'h0;
               3'h2: st <= a_q != UNLOCK1_ADDR ? 3'h0 : dq_i == CMD_PROG ? 3'h3
                     : dq_i == CMD_AUTOSEL ? 3'h4 : dq_i == CMD_BYPASS ? 3'h5 : 3'h0;
               3'h3: begin prog(a_q, dq_i); st <= 3'h0; end
               3'h5: st <= dq_i == CMD_BYP_PROG ? 3'h6 : dq_i == CMD_BYP_EX1 ? 3'h7 : 3'h5;
               3'h6: begin prog(a_q, dq_i); st <= 3'h5; end
               3'h7: st <= dq_i == CMD_BYP_EX2 ? 3'h0 : 3'h5;
               default: st <= st;
            endcase
endmodule

//--- fcs_host_ctrl_tb.sv
/* Self-checking bench: AXI4-Lite master tasks, flash model on the pins.
   Assumes every AXI answer comes within the bench's wait bound. */
`timescale 1ns/1ps
module fcs_host_ctrl_tb
   import fcs_pkg::*;
;
   localparam logic [15:0] MFR = 16'h00c3; // Arbitrary value
   localparam logic [15:0] DEV = 16'h5a3c; // Arbitrary value
   logic              ref_clk = 1'b0, srst = 1'b1;
   logic [7:0]        awaddr = 8'h0, araddr = 8'h0;
   logic [31:0]       wdata = 32'h0, rdata;
   logic [3:0]        wstrb = 4'hf;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [1:0]        bresp, rresp;
   logic              ce_n, we_n, oe_n, dq_oe, byte_n, rst_n, hv, rb_n;
   logic [ADDR_W-1:0] fa;
   logic [DATA_W-1:0] hdq, mdq, bus;
   int                n_errors = 0, checks = 0;
   assign bus = dq_oe ? hdq : mdq;
   always #4 ref_clk = ~ref_clk;
   fcs_host_ctrl u_fcs_host_ctrl (.ref_clk_i(ref_clk), .srst_i(srst),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .flash_ce_n_o(ce_n),
      .flash_we_n_o(we_n), .flash_oe_n_o(oe_n), .flash_addr_o(fa), .flash_dq_i(bus),
      .flash_dq_o(hdq), .flash_dq_oe_o(dq_oe), .flash_byte_n_o(byte_n),
      .flash_reset_n_o(rst_n), .id_high_voltage_en_o(hv), .ready_busy_pin_n_i(rb_n));
   fcs_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_fcs_flash_model (.ce_n_i(ce_n),
      .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(fa), .dq_i(bus), .byte_n_i(byte_n),
      .reset_n_i(rst_n), .hv_i(hv), .dq_o(mdq), .rb_n_o(rb_n));
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic stop();
      n_errors++;
      summarize();
   endtask
   task automatic wt(ref logic s);
      int i;
      for (i = 0; i < 200 && s !== 1'b1; i++) @(posedge ref_clk);
      if (s !== 1'b1) stop();
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      wt(awready);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      wt(bvalid);
      r = bresp;
      bready <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      wt(arready);
      arvalid <= 1'b0;
      wt(rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic op(input logic [3:0] o, input logic [ADDR_W-1:0] a, input logic [15:0] d);
      logic [1:0]  r;
      logic [31:0] v;
      int          i;
      axw(REG_ADDR, {14'h0, a}, r);
      axw(REG_WDATA, {16'h0, d}, r);
      axw(REG_CTRL, {1'b1, 27'h0, o}, r);
      v = 32'h1;
      for (i = 0; i < 200 && v[STAT_BUSY_BIT] !== 1'b0; i++) axr(REG_STATUS, v, r);
      if (v[STAT_BUSY_BIT] !== 1'b0) stop();
   endtask
   task automatic rda(input logic [ADDR_W-1:0] a, input logic [15:0] e);
      logic [1:0]  r;
      logic [31:0] v;
      op(OP_READ, a, 16'h0);
      axr(REG_RDATA, v, r);
      chk(v, {16'h0, e});
   endtask
   task automatic sbit(input int b, input logic e);
      logic [1:0]  r;
      logic [31:0] v;
      axr(REG_STATUS, v, r);
      chk({31'h0, v[b]}, {31'h0, e});
   endtask
   task automatic seq(input logic [ADDR_W-1:0] a2, input logic [15:0] d3);
      op(OP_RAW_WRITE, UNLOCK1_ADDR, UNLOCK1_DATA);
      op(OP_RAW_WRITE, a2, UNLOCK2_DATA);
      op(OP_RAW_WRITE, UNLOCK1_ADDR, d3);
      op(OP_RAW_WRITE, 18'h7, 16'h0);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_regs();
      logic [1:0]  r;
      logic [31:0] v;
      axr(REG_CFG, v, r);
      chk(v, {29'h0, CFG_RESET});
      axw(REG_CFG, 32'h7, r);
      chk({29'h0, byte_n, rst_n, hv}, 32'h1);
      axw(REG_CFG, 32'h0, r);
      chk({29'h0, byte_n, rst_n, hv}, 32'h6);
      axr(8'h20, v, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      axw(REG_STATUS, 32'h0, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
   endtask
   task automatic t_prog();
      logic [1:0] r;
      rda(18'h3, 16'hffff);
      op(OP_PROG, 18'h3, 16'h12f0);
      rda(18'h3, 16'h12f0);
      sbit(STAT_RB_BIT, 1'b1);
      op(OP_PROG, 18'h3, 16'hff0f);
      rda(18'h3, 16'h1200);
      op(OP_PROG, 18'h20001, 16'h0);
      rda(18'h20001, 16'hffff);
      axw(REG_CFG, 32'h4, r);
      op(OP_PROG, 18'h20001, 16'h00ff);
      axw(REG_CFG, 32'h0, r);
      rda(18'h20001, 16'h00ff);
   endtask
   task automatic t_auto();
      op(OP_AUTOSEL, 18'h0, 16'h0);
      sbit(STAT_AUTO_BIT, 1'b1);
      rda(18'h0, MFR);
      rda(18'h1, DEV);
      rda(18'h20002, 16'h1);
      rda(18'h2, 16'h0);
      op(OP_PROG, 18'h3, 16'h0);
      sbit(STAT_ERR_BIT, 1'b1);
      op(OP_RESET, 18'h3ffff, 16'h0);
      sbit(STAT_AUTO_BIT, 1'b0);
      rda(18'h3, 16'h1200);
   endtask
   task automatic t_byp();
      op(OP_BYP_PROG, 18'h4, 16'h0);
      sbit(STAT_ERR_BIT, 1'b1);
      op(OP_BYP_ENTER, 18'h0, 16'h0);
      sbit(STAT_BYPASS_BIT, 1'b1);
      op(OP_PROG, 18'h4, 16'h0);
      sbit(STAT_ERR_BIT, 1'b1);
      op(OP_BYP_PROG, 18'h4, 16'h00a5);
      op(OP_BYP_PROG, 18'h5, 16'h5a00);
      op(OP_BYP_EXIT, 18'h0, 16'h0);
      sbit(STAT_BYPASS_BIT, 1'b0);
      rda(18'h4, 16'h00a5);
      rda(18'h5, 16'h5a00);
   endtask
   task automatic t_raw();
      seq(UNLOCK2_ADDR, CMD_RESET);
      rda(18'h7, 16'hffff);
      seq(18'h123, CMD_PROG);
      rda(18'h7, 16'hffff);
      seq(UNLOCK2_ADDR, CMD_PROG);
      rda(18'h7, 16'h0);
   endtask
   initial
   begin
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      t_regs();
      t_prog();
      t_auto();
      t_byp();
      t_raw();
      summarize();
   end
endmodule
